// File: dss_unit.sv
// Functional notes
// - rotate-insert: rotate by shift field, mask mask_begin..63-shift, merge into dest.
// - record bit one updates first condition field; zero leaves it untouched.
// - on a 32-bit implementation the doubleword rotate/shift opcodes trap illegal.
// - segment-buffer invalidates trap illegal on the 32-bit implementation.
// - invalidate-all clears every segment buffer entry, relocate bits ignored.
// - invalidate-by-address searches by second source, invalidates matches, ignores block translation.
// - invalidate-by-index clears entry N given by second source, relocate bits ignored.
// - the three invalidates are privileged: supervisor state only.
// - invalidates never consult the address space register.
// - shift-left by 7-bit amount, zero fill; amounts 64..127 give zero.
// - logical shift-right by 7-bit amount, zero fill; 64 or more gives zero.
// - arithmetic shift-right fills with sign; carry only if negative and ones lost.
// - arithmetic shift-right by zero passes source and clears carry.
// - register arithmetic shift by 64..127 gives all sign bits, carry equals sign.
`timescale 1ns/1ps
`include "dss_map.svh"

module dss_unit (
   input  wire logic                clk,               // core clock, 10 MHz
   input  wire logic                reset,             // async, active high
   input  wire dss_pkg::dss_issue_t issue,             // decoded instruction and operands
   input  wire dss_pkg::dss_fill_t  fill,              // segment buffer load port
   input  wire logic                impl64,            // 1: 64-bit ops execute
   input  wire logic                supervisor,        // machine in supervisor state
   input  wire logic                summary_ovf,       // fixed-point summary overflow
   output logic                     res_valid,         // one-cycle completion pulse
   output logic [63:0]              result,            // value for dest_gpr
   output logic                     cr0_we,            // first_condition_field write
   output logic [3:0]               cr0,               // {lt, gt, eq, so}
   output logic                     ca_we,             // carry_flag write
   output logic                     carry_flag,        // new carry value
   output logic                     illegal_trap,      // illegal-instruction pulse
   output logic                     priv_trap,         // privileged-op program pulse
   output logic [15:0]              sb_valid           // segment buffer valid bits
);

   dss_pkg::dss_state_t st_reg;
   dss_pkg::dss_state_t st_next;

   logic [63:0] rot;
   logic [63:0] msk;
   logic [6:0]  amt;
   logic [5:0]  mask_end;
   logic        is_shift;
   logic        is_sb;
   logic        exec;
   logic        sign;
   logic [63:0] sra_res;
   logic [63:0] lost_mask;
   logic [15:0] hit_vec;
   logic [63:0] res;
   logic        ca;

   // ==================================================
   // rotate and mask for the insert form
   always_comb begin
      mask_end = 6'h3F - issue.shift_field;
   end

   dss_rotl64 u_rot (
      .din  (issue.source_gpr),
      .amt  (issue.shift_field),
      .dout (rot)
   );

   dss_mask64 u_msk (
      .mb   (issue.mask_begin),
      .me   (mask_end),
      .mask (msk)
   );

   // ==================================================
   // operand classification and the shift data path
   always_comb begin
      is_shift = issue.valid && (issue.op inside {dss_pkg::DSS_OP_RLDIMI,
                 dss_pkg::DSS_OP_SLD, dss_pkg::DSS_OP_SRD,
                 dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI});
      is_sb    = issue.valid && !is_shift;
      exec     = impl64 && (is_shift || (is_sb && supervisor));
      sign     = issue.source_gpr[`DSS_SIGN_BIT];
      // immediate form can never reach 64, so its top amount bit is zero
      amt = (issue.op == dss_pkg::DSS_OP_SRADI) ? {1'b0, issue.shift_field}
                                                : issue.second_source_gpr[6:0];
      sra_res   = 64'($signed(issue.source_gpr) >>> amt[5:0]);
      lost_mask = ~({64{1'b1}} << amt[5:0]);
      res = 64'h0000_0000_0000_0000;
      ca  = 1'b0;
      unique case (issue.op)
         dss_pkg::DSS_OP_RLDIMI: begin
            res = (rot & msk) | (issue.dest_gpr & ~msk);
         end
         dss_pkg::DSS_OP_SLD: begin
            res = amt[`DSS_AMT_BIG_BIT] ? 64'h0000_0000_0000_0000
                                        : issue.source_gpr << amt[5:0];
         end
         dss_pkg::DSS_OP_SRD: begin
            res = amt[`DSS_AMT_BIG_BIT] ? 64'h0000_0000_0000_0000
                                        : issue.source_gpr >> amt[5:0];
         end
         dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI: begin
            if (amt[`DSS_AMT_BIG_BIT]) begin
               res = {64{sign}};
               ca  = sign;
            end else begin
               res = sra_res;
               // zero amount gives an empty lost mask, so carry clears
               ca  = sign && |(issue.source_gpr & lost_mask);
            end
         end
         default: begin
            res = 64'h0000_0000_0000_0000;
            ca  = 1'b0;
         end
      endcase
   end

   // ==================================================
   // segment buffer search; relocate bits and address space register
   // are deliberately not inputs, so they cannot steer invalidation
   always_comb begin
      for (int i = 0; i < `DSS_SB_ENTRIES; i++) begin
         hit_vec[i] = st_reg.sb_valid[i] && (st_reg.sb_tag[i] ==
            issue.second_source_gpr[63:`DSS_ESID_LSB]);
      end
   end

   // ==================================================
   // next state
   always_comb begin
      st_next              = st_reg;
      st_next.res_valid    = 1'b0;
      st_next.cr0_we       = 1'b0;
      st_next.ca_we        = 1'b0;
      st_next.illegal_trap = issue.valid && !impl64;
      st_next.priv_trap    = is_sb && impl64 && !supervisor;
      if (is_shift && impl64) begin
         st_next.res_valid = 1'b1;
         st_next.result    = res;
         if (issue.record_bit) begin
            st_next.cr0_we = 1'b1;
            st_next.cr0[`DSS_CR_LT] = res[`DSS_SIGN_BIT];
            st_next.cr0[`DSS_CR_GT] = !res[`DSS_SIGN_BIT] && (res != 64'h0);
            st_next.cr0[`DSS_CR_EQ] = (res == 64'h0000_0000_0000_0000);
            st_next.cr0[`DSS_CR_SO] = summary_ovf;
         end
         if (issue.op inside {dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI}) begin
            st_next.ca_we      = 1'b1;
            st_next.carry_flag = ca;
         end
      end
      if (is_sb && exec) begin
         st_next.res_valid = 1'b1;
         unique case (issue.op)
            dss_pkg::DSS_OP_SB_ALL: begin
               st_next.sb_valid = `DSS_SB_VALID_RST;
            end
            dss_pkg::DSS_OP_SB_EA: begin
               st_next.sb_valid = st_reg.sb_valid & ~hit_vec;
            end
            dss_pkg::DSS_OP_SB_IDX: begin
               // an index beyond the buffer touches nothing
               if (issue.second_source_gpr[63:`DSS_SB_IDX_W] == '0) begin
                  st_next.sb_valid[issue.second_source_gpr[3:0]] = 1'b0;
               end
            end
            default: begin
               st_next.sb_valid = st_reg.sb_valid;
            end
         endcase
      end
      // a load in the same cycle as an invalidate wins
      if (fill.en) begin
         st_next.sb_valid[fill.index] = 1'b1;
         st_next.sb_tag[fill.index]   = fill.esid;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      res_valid    = st_reg.res_valid;
      result       = st_reg.result;
      cr0_we       = st_reg.cr0_we;
      cr0          = st_reg.cr0;
      ca_we        = st_reg.ca_we;
      carry_flag   = st_reg.carry_flag;
      illegal_trap = st_reg.illegal_trap;
      priv_trap    = st_reg.priv_trap;
      sb_valid     = st_reg.sb_valid;
   end

   // ==================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic        go_rl;
   logic        go_sh;
   logic [63:0] ref_rot;
   always_comb begin
      go_rl   = issue.valid && impl64 && issue.op == dss_pkg::DSS_OP_RLDIMI;
      go_sh   = is_shift && impl64;
      ref_rot = (issue.source_gpr << issue.shift_field) |
                (issue.source_gpr >> (7'h40 - {1'b0, issue.shift_field}));
   end

   rot_insert_a: assert property (go_rl |=> result ==
      (($past(ref_rot) & $past(msk)) | ($past(issue.dest_gpr) & ~$past(msk))))
      else $error("rotate-insert result wrong");
   cr_record_a: assert property (go_sh |=> cr0_we == $past(issue.record_bit))
      else $error("condition field write does not follow record bit");
   illegal_64_a: assert property (is_shift && !impl64 |=>
      illegal_trap && !res_valid && !ca_we)
      else $error("64-bit shift executed on 32-bit implementation");
   sb_illegal_a: assert property (is_sb && !impl64 && !fill.en |=>
      illegal_trap && sb_valid == $past(sb_valid))
      else $error("segment invalidate executed on 32-bit implementation");
   inval_all_a: assert property (is_sb && exec && !fill.en &&
      issue.op == dss_pkg::DSS_OP_SB_ALL |=> sb_valid == 16'h0000)
      else $error("invalidate-all left an entry valid");
   inval_ea_a: assert property (is_sb && exec && !fill.en &&
      issue.op == dss_pkg::DSS_OP_SB_EA |=>
      (sb_valid & $past(hit_vec)) == 16'h0000 &&
      (sb_valid | $past(hit_vec)) == $past(sb_valid))
      else $error("invalidate-by-address wrong entries");
   inval_idx_a: assert property (is_sb && exec && !fill.en &&
      issue.op == dss_pkg::DSS_OP_SB_IDX &&
      issue.second_source_gpr[63:4] == '0 |=>
      !sb_valid[$past(issue.second_source_gpr[3:0])])
      else $error("invalidate-by-index left entry valid");
   priv_a: assert property (is_sb && impl64 && !supervisor && !fill.en |=>
      priv_trap && !res_valid && $stable(sb_valid))
      else $error("privileged invalidate ran in user state");
   sld_big_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_SLD &&
      issue.second_source_gpr[6] |=> result == 64'h0000_0000_0000_0000)
      else $error("shift-left by 64 or more not zero");
   srd_big_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_SRD &&
      issue.second_source_gpr[6] |=> result == 64'h0000_0000_0000_0000)
      else $error("logical shift-right by 64 or more not zero");
   sra_pos_a: assert property (go_sh && !sign &&
      issue.op inside {dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI} |=>
      ca_we && !carry_flag && !result[63])
      else $error("carry set for positive source");
   sra_zero_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_SRADI &&
      issue.shift_field == 6'h00 |=>
      result == $past(issue.source_gpr) && !carry_flag)
      else $error("zero arithmetic shift altered value or carry");
   sra_big_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH &&
      issue.second_source_gpr[6] |=>
      result == {64{$past(sign)}} && carry_flag == $past(sign))
      else $error("arithmetic shift by 64 or more wrong");
   cr_cmp_a: assert property (cr0_we |-> cr0[1] == (result == 64'h0) &&
      cr0[3] == result[63] && !(cr0[3] && cr0[2]))
      else $error("condition field disagrees with result");

   // ==================================================
   // priority, completion, hold and shift result checks
   ill_prio_a: assert property (issue.valid && !impl64 |=>
      !priv_trap && !res_valid && !cr0_we)
      else $error("completion or privilege trap on a 32-bit implementation");
   priv_ok_a: assert property (is_sb && impl64 && supervisor |=>
      res_valid && !priv_trap && !illegal_trap)
      else $error("supervisor invalidate did not complete");
   cr_hold_a: assert property (!(go_sh && issue.record_bit) |=> $stable(cr0))
      else $error("condition field changed without record bit");
   res_hold_a: assert property (!go_sh |=> $stable(result))
      else $error("result changed without a completing shift");
   sld_small_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_SLD &&
      !issue.second_source_gpr[6] |=> result ==
      ($past(issue.source_gpr) << $past(issue.second_source_gpr[5:0])))
      else $error("shift-left below 64 wrong");
   srd_small_a: assert property (go_sh && issue.op == dss_pkg::DSS_OP_SRD &&
      !issue.second_source_gpr[6] |=> result ==
      ($past(issue.source_gpr) >> $past(issue.second_source_gpr[5:0])))
      else $error("logical shift-right below 64 wrong");
   sra_neg_a: assert property (go_sh && sign &&
      issue.op inside {dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI} |=>
      ca_we && result[63])
      else $error("sign not replicated for negative source");
   ca_only_a: assert property (go_sh &&
      !(issue.op inside {dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI}) |=> !ca_we)
      else $error("carry written by a non-arithmetic shift");
   fill_win_a: assert property (fill.en && is_sb && exec |=>
      sb_valid[$past(fill.index)])
      else $error("segment load lost to a same-cycle invalidate");

   // ==================================================
   // main scenarios

   rot_cov_c: cover property (go_rl && issue.record_bit ##1 cr0_we);
   sra_ca_c: cover property (go_sh && issue.op == dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH ##1 carry_flag);
   sb_ea_c: cover property (is_sb && exec && |hit_vec ##1 res_valid);
   ill_c: cover property (issue.valid && !impl64 ##1 illegal_trap);
   priv_c: cover property (is_sb && impl64 && !supervisor ##1 priv_trap);

endmodule : dss_unit

// File: dss_map.svh
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

// ==================================================
// data path widths and shift amount fields
`define DSS_XLEN          64
`define DSS_AMT_W         7
`define DSS_AMT_BIG_BIT   6
`define DSS_SIGN_BIT      63

// ==================================================
// segment buffer geometry: the tag is the effective address top 36 bits
`define DSS_SB_ENTRIES    16
`define DSS_SB_IDX_W      4
`define DSS_ESID_W        36
`define DSS_ESID_LSB      28
`define DSS_SB_VALID_RST  16'h0000

// ==================================================
// first condition field bit positions {lt, gt, eq, so}
`define DSS_CR_LT         3
`define DSS_CR_GT         2
`define DSS_CR_EQ         1
`define DSS_CR_SO         0

// ==================================================
// extended opcode of the invalidate-all instruction (decoder side)
`define DSS_XO_SB_INV_ALL 10'h1F2

`endif

// File: dss_pkg.sv
package dss_pkg;

   // ==================================================
   // operations handed over by the decoder
   typedef enum logic [2:0] {
      DSS_OP_RLDIMI = 3'h0,
      DSS_OP_SLD    = 3'h1,
      DSS_OP_SRD    = 3'h3,
      DSS_OP_DWORD_SHIFT_RIGHT_ARITH   = 3'h2,
      DSS_OP_SRADI  = 3'h6,
      DSS_OP_SB_ALL = 3'h7,
      DSS_OP_SB_EA  = 3'h5,
      DSS_OP_SB_IDX = 3'h4
   } dss_op_t;

   typedef struct packed {
      logic        valid;
      dss_op_t     op;
      logic        record_bit;
      logic [5:0]  shift_field;
      logic [5:0]  mask_begin;
      logic [63:0] source_gpr;
      logic [63:0] dest_gpr;
      logic [63:0] second_source_gpr;
   } dss_issue_t;

   typedef struct packed {
      logic        en;
      logic [3:0]  index;
      logic [35:0] esid;
   } dss_fill_t;

   typedef struct packed {
      logic              res_valid;
      logic [63:0]       result;
      logic              cr0_we;
      logic [3:0]        cr0;
      logic              ca_we;
      logic              carry_flag;
      logic              illegal_trap;
      logic              priv_trap;
      logic [15:0]       sb_valid;
      logic [15:0][35:0] sb_tag;
   } dss_state_t;

endpackage : dss_pkg

// File: dss_rotl64.sv
`timescale 1ns/1ps
`include "dss_map.svh"

module dss_rotl64 (
   input  wire logic [63:0] din,     // value to rotate
   input  wire logic [5:0]  amt,     // left rotate count
   output logic      [63:0] dout     // rotated value
);

   logic [127:0] dbl;

   // ==================================================
   // rotate by shifting a doubled copy; no wrap logic needed
   always_comb begin
      dbl  = {din, din} << amt;
      dout = dbl[127:64];
   end

endmodule : dss_rotl64

// File: dss_mask64.sv
`timescale 1ns/1ps
`include "dss_map.svh"

module dss_mask64 (
   input  wire logic [5:0]  mb,      // first one bit, msb-first numbering
   input  wire logic [5:0]  me,      // last one bit, msb-first numbering
   output logic      [63:0] mask     // generated mask, lsb-first vector
);

   logic [63:0] from_b;
   logic [63:0] to_e;
   logic [6:0]  e_plus;

   // ==================================================
   // msb-first bit k is vector bit 63-k; begin past end wraps around
   always_comb begin
      e_plus = {1'b0, me} + 7'h01;
      from_b = {64{1'b1}} >> mb;
      to_e   = ~({64{1'b1}} >> e_plus);
      mask   = (mb <= me) ? (from_b & to_e) : (from_b | to_e);
   end

endmodule : dss_mask64

// File: dss_gpr_model.sv
`timescale 1ns/1ps

// ==================================================
// decoder and register file seen from the unit
module dss_gpr_model (
   input  wire logic                clk,        // core clock
   input  wire logic                reset,      // async, active high
   input  wire dss_pkg::dss_issue_t req,        // instruction from the test sequence
   input  wire logic                res_valid,  // completion pulse from the unit
   input  wire logic [63:0]         result,     // value for the destination register
   output dss_pkg::dss_issue_t      issue,      // decoded instruction to the unit
   output logic      [63:0]         wb_reg      // last value written back
);
   // decode adds no stage, so the unit sees the request in the cycle it is made
   assign issue = req;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_reg <= 64'h0;
      end else if (res_valid) begin
         wb_reg <= result;
      end
   end
endmodule : dss_gpr_model

// File: tb_dss_unit.sv
`timescale 1ns/1ps

module tb_dss_unit;
   logic                clk;
   logic                reset;
   dss_pkg::dss_issue_t req;
   dss_pkg::dss_issue_t issue;
   dss_pkg::dss_fill_t  fill_r;
   logic                impl64;
   logic                supervisor;
   logic                summary_ovf;
   logic                res_valid;
   logic [63:0]         result;
   logic                cr0_we;
   logic [3:0]          cr0;
   logic                ca_we;
   logic                carry_flag;
   logic                illegal_trap;
   logic                priv_trap;
   logic [15:0]         sb_valid;
   logic [63:0]         gpr_wb;
   int                  err_total;
   int                  checked;
   dss_pkg::dss_op_t    shops [3] = '{dss_pkg::DSS_OP_SLD, dss_pkg::DSS_OP_SRD,
                                      dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH};
   logic [63:0]         amts [6]  = '{64'h0, 64'h1, 64'h3F, 64'h40, 64'h7F,
                                      64'hFFFF_FFFF_FFFF_FF85};

   dss_unit u_dss_unit (.clk(clk), .reset(reset), .issue(issue), .fill(fill_r),
      .impl64(impl64), .supervisor(supervisor), .summary_ovf(summary_ovf),
      .res_valid(res_valid), .result(result), .cr0_we(cr0_we), .cr0(cr0),
      .ca_we(ca_we), .carry_flag(carry_flag), .illegal_trap(illegal_trap),
      .priv_trap(priv_trap), .sb_valid(sb_valid));

   dss_gpr_model u_dss_gpr_model (.clk(clk), .reset(reset), .req(req),
      .res_valid(res_valid), .result(result), .issue(issue), .wb_reg(gpr_wb));

   // ==================================================
   // reporting
   task automatic end_sim;
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // ==================================================
   // access tasks; mode 0 executes, 1 expects illegal, 2 expects privilege trap
   task automatic exec(input dss_pkg::dss_op_t op, input logic rc, input logic [5:0] sh,
      input logic [5:0] mb, input logic [63:0] rs, input logic [63:0] rd,
      input logic [63:0] rb, input logic [1:0] mode);
      logic [63:0] r;
      logic [63:0] m;
      logic [6:0]  n;
      logic        ca;
      logic        sh_op;
      logic        sra;
      logic [3:0]  cr_prev;
      int          me;
      n = rb[6:0];
      ca = 1'b0;
      r = 64'h0;
      m = 64'h0;
      sra = op inside {dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, dss_pkg::DSS_OP_SRADI};
      sh_op = !(op inside {dss_pkg::DSS_OP_SB_ALL, dss_pkg::DSS_OP_SB_EA,
                           dss_pkg::DSS_OP_SB_IDX});
      if (op == dss_pkg::DSS_OP_SRADI) n = {1'b0, sh};
      if (op == dss_pkg::DSS_OP_SLD && !n[6]) r = rs << n[5:0];
      if (op == dss_pkg::DSS_OP_SRD && !n[6]) r = rs >> n[5:0];
      if (sra) begin
         if (n[6]) r = {64{rs[63]}};
         else r = $signed(rs) >>> n[5:0];
         ca = rs[63] & (n[6] | ((rs & ~(64'hFFFF_FFFF_FFFF_FFFF << n[5:0])) != 64'h0));
      end
      if (op == dss_pkg::DSS_OP_RLDIMI) begin
         me = 63 - sh;
         for (int i = 0; i < 64; i++) begin
            m[63-i] = (mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me);
         end
         r = (((rs << sh) | (rs >> (64 - sh))) & m) | (rd & ~m);
      end
      @(posedge clk);
      cr_prev = cr0;
      req <= '{valid:1'b1, op:op, record_bit:rc, shift_field:sh, mask_begin:mb,
               source_gpr:rs, dest_gpr:rd, second_source_gpr:rb};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      check(res_valid, mode == 2'd0);
      check(illegal_trap, mode == 2'd1);
      check(priv_trap, mode == 2'd2);
      if (mode == 2'd0 && sh_op) begin
         check(result, r);
         check(cr0_we, rc);
         if (rc) check(cr0, {r[63], ~r[63] & (r != 64'h0), r == 64'h0, summary_ovf});
         else check(cr0, cr_prev);
         check(ca_we, sra);
         if (sra) check(carry_flag, ca);
         @(posedge clk);
         #1;
         check(gpr_wb, r);
      end else begin
         check({cr0_we, ca_we}, 2'b00);
      end
   endtask : exec

   task automatic load_entry(input logic [3:0] idx, input logic [35:0] tag);
      @(posedge clk);
      fill_r <= '{en:1'b1, index:idx, esid:tag};
      @(posedge clk);
      fill_r.en <= 1'b0;
      #1;
   endtask : load_entry

   // ==================================================
   // clock, watchdog and sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim;
   end

   initial begin
      err_total = 0;
      checked = 0;
      reset = 1'b1;
      req = '0;
      fill_r = '0;
      impl64 = 1'b1;
      supervisor = 1'b1;
      summary_ovf = 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      exec(dss_pkg::DSS_OP_DWORD_SHIFT_RIGHT_ARITH, 1'b1, 6'h0, 6'h0, 64'h8000_0000_0000_0007, 64'h0, 64'h3, 2'd0);
      foreach (amts[k]) begin
         for (int o = 0; o < 3; o++) begin
            exec(shops[o], 1'(k), 6'h0, 6'h0, 64'hC3A5_0000_0000_F00F, 64'h0, amts[k], 2'd0);
         end
      end
      @(posedge clk);
      summary_ovf <= 1'b0;
      exec(dss_pkg::DSS_OP_SRADI, 1'b1, 6'h00, 6'h0, 64'hF123_4567_89AB_CDEF, 64'h0, 64'h0, 2'd0);
      exec(dss_pkg::DSS_OP_SRADI, 1'b1, 6'h04, 6'h0, 64'h8000_0000_0000_0010, 64'h0, 64'h0, 2'd0);
      exec(dss_pkg::DSS_OP_SRADI, 1'b0, 6'h3F, 6'h0, 64'h7000_0000_0000_0001, 64'h0, 64'h0, 2'd0);
      exec(dss_pkg::DSS_OP_RLDIMI, 1'b1, 6'h08, 6'h10, 64'h1234_5678_9ABC_DEF0,
           64'hFFFF_0000_FFFF_0000, 64'h0, 2'd0);
      exec(dss_pkg::DSS_OP_RLDIMI, 1'b0, 6'h30, 6'h20, 64'h0F0F_1111_2222_3333,
           64'hAAAA_5555_AAAA_5555, 64'h0, 2'd0);
      exec(dss_pkg::DSS_OP_RLDIMI, 1'b1, 6'h00, 6'h00, 64'h8000_0000_0000_0000, 64'h1, 64'h0, 2'd0);
      for (int i = 0; i < 4; i++) load_entry(4'(i), 36'hA_0000_0000 | 36'(i));
      check(sb_valid, 16'h000F);
      @(posedge clk);
      impl64 <= 1'b0;
      for (int o = 0; o < 8; o++) begin
         exec(dss_pkg::dss_op_t'(3'(o)), 1'b1, 6'h1, 6'h0, 64'hFF, 64'h0, 64'h0, 2'd1);
      end
      check(sb_valid, 16'h000F);
      @(posedge clk);
      impl64 <= 1'b1;
      supervisor <= 1'b0;
      exec(dss_pkg::DSS_OP_SB_ALL, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h0, 2'd2);
      exec(dss_pkg::DSS_OP_SB_EA, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'hA000_0000_0000_0000, 2'd2);
      exec(dss_pkg::DSS_OP_SB_IDX, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h1, 2'd2);
      check(sb_valid, 16'h000F);
      @(posedge clk);
      supervisor <= 1'b1;
      exec(dss_pkg::DSS_OP_SB_EA, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0,
           {36'hA_0000_0001, 28'h5A5_5A5A}, 2'd0);
      check(sb_valid, 16'h000D);
      exec(dss_pkg::DSS_OP_SB_IDX, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h2, 2'd0);
      check(sb_valid, 16'h0009);
      exec(dss_pkg::DSS_OP_SB_IDX, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h12, 2'd0);
      check(sb_valid, 16'h0009);
      exec(dss_pkg::DSS_OP_SB_ALL, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h0, 2'd0);
      check(sb_valid, 16'h0000);
      @(posedge clk);
      fill_r <= '{en:1'b1, index:4'h5, esid:36'hB_0000_0005};
      exec(dss_pkg::DSS_OP_SB_ALL, 1'b0, 6'h0, 6'h0, 64'h0, 64'h0, 64'h0, 2'd0);
      check(sb_valid, 16'h0020);
      @(posedge clk);
      fill_r.en <= 1'b0;
      end_sim;
   end
endmodule : tb_dss_unit
